// ==== lsfs_map.svh ====
`ifndef LSFS_MAP_SVH
`define LSFS_MAP_SVH

// flash timing, in milliseconds, and the clock period in picoseconds
`define LSFS_CLK_PERIOD_PS    5000
`define LSFS_CLK_HZ           200000000
`define LSFS_TICK_US          1000
`define LSFS_ON_MS            150
`define LSFS_GAP_MS           250
`define LSFS_FRAME_GAP_MS     1000
// cycles of one prescaler tick (1 ms at 200 MHz)
`define LSFS_TICK_CYCLES      ((`LSFS_CLK_HZ / 1000000) * `LSFS_TICK_US)
// count widths
`define LSFS_CNT_W            6
`define LSFS_MS_W             11
`define LSFS_PRE_W            18
// colour code field positions on the led bus
`define LSFS_LED_RED_BIT      1
`define LSFS_LED_GREEN_BIT    0

`endif

// ==== lsfs_pkg.sv ====
package lsfs_pkg;
    typedef enum logic [1:0]
    {
        LSFS_OFF,
        LSFS_RED,
        LSFS_GREEN,
        LSFS_YELLOW
    } lsfs_colour_t;

    typedef struct packed
    {
        logic       red;
        logic       green;
    } lsfs_led_t;

    typedef struct packed
    {
        logic       power_good;
        logic [5:0] gps_sbas_cnt;
        logic [5:0] glonass_cnt;
    } lsfs_status_t;
endpackage

// ==== lsfs_flash_timer.sv ====
`include "lsfs_map.svh"

module lsfs_flash_timer
    import lsfs_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   start_in,
    input  wire logic [`LSFS_MS_W-1:0]  on_ms_in,
    input  wire logic [`LSFS_MS_W-1:0]  gap_ms_in,
    output logic                        lit_out,
    output logic                        done_out
);
    ////////////////////////////////////////////////////////////////////////////
    // one flash: lit for on_ms, then dark for gap_ms, then a done pulse
    logic [`LSFS_PRE_W-1:0] pre_r;
    logic [`LSFS_PRE_W-1:0] pre_nxt;
    logic [`LSFS_MS_W-1:0]  ms_r;
    logic [`LSFS_MS_W-1:0]  ms_nxt;
    logic                   busy_r;
    logic                   busy_nxt;
    logic                   lit_r;
    logic                   lit_nxt;
    logic                   done_r;
    logic                   done_nxt;
    logic                   tick;

    always_comb
    begin
        tick     = (pre_r == `LSFS_PRE_W'(`LSFS_TICK_CYCLES - 1));
        pre_nxt  = (tick || !busy_r) ? '0 : pre_r + 1'b1;
        ms_nxt   = ms_r;
        busy_nxt = busy_r;
        lit_nxt  = lit_r;
        done_nxt = 1'b0;
        if (!busy_r)
        begin
            if (start_in)
            begin
                busy_nxt = 1'b1;
                lit_nxt  = 1'b1;
                ms_nxt   = on_ms_in;
            end
        end
        else if (tick)
        begin
            if (ms_r > `LSFS_MS_W'(1))
            begin
                ms_nxt = ms_r - 1'b1;
            end
            else if (lit_r && gap_ms_in != '0)
            begin
                lit_nxt = 1'b0;
                ms_nxt  = gap_ms_in;
            end
            else
            begin
                lit_nxt  = 1'b0;
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pre_r  <= '0;
            ms_r   <= '0;
            busy_r <= 1'b0;
            lit_r  <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            pre_r  <= pre_nxt;
            ms_r   <= ms_nxt;
            busy_r <= busy_nxt;
            lit_r  <= lit_nxt;
            done_r <= done_nxt;
        end
    end

    assign lit_out  = lit_r;
    assign done_out = done_r;
endmodule

// ==== lsfs_led_sequencer.sv ====
// How it works
// [R1] frame opens with one red power flash
// [R2] then green flashes, one per GPS/SBAS lock
// [R3] one yellow flash ends first green run
// [R4] then green flashes, one per GLONASS lock
// [R5] red closes frame, frame then repeats while power good holds
// [R6] no lock: uniform red, yellow alternation
// [R7] fixed prescaled flash timing; counts sampled at start
`include "lsfs_map.svh"

module lsfs_led_sequencer
    import lsfs_pkg::*;
(
    input  wire logic                   CLK_IN,
    input  wire logic                   RST_IN,
    input  wire logic                   POWER_GOOD_IN,
    input  wire logic [`LSFS_CNT_W-1:0] GPS_SBAS_CNT_IN,
    input  wire logic [`LSFS_CNT_W-1:0] GLONASS_CNT_IN,
    output lsfs_led_t                   LED_OUT,
    output logic                        FRAME_START_OUT
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser: three flops, a change counts when the last two agree
    lsfs_status_t s1_r;
    lsfs_status_t s2_r;
    lsfs_status_t s3_r;
    lsfs_status_t st_r;
    lsfs_status_t st_nxt;
    lsfs_status_t raw;

    always_comb
    begin
        raw.power_good   = POWER_GOOD_IN;
        raw.gps_sbas_cnt = GPS_SBAS_CNT_IN;
        raw.glonass_cnt  = GLONASS_CNT_IN;
        st_nxt           = (s2_r == s3_r) ? s3_r : st_r;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            st_r <= '0;
        end
        else
        begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame sequencer
    typedef enum logic [2:0]
    {
        SQ_IDLE,
        SQ_OPEN_RED,
        SQ_GREEN_A,
        SQ_YELLOW,
        SQ_GREEN_B,
        SQ_CLOSE_RED,
        SQ_NOLOCK_RED,
        SQ_NOLOCK_YEL
    } lsfs_seq_t;

    function automatic lsfs_colour_t colour_of(input lsfs_seq_t s);
        case (s)
            SQ_OPEN_RED, SQ_CLOSE_RED, SQ_NOLOCK_RED: colour_of = LSFS_RED;
            SQ_GREEN_A, SQ_GREEN_B:                   colour_of = LSFS_GREEN;
            SQ_YELLOW, SQ_NOLOCK_YEL:                 colour_of = LSFS_YELLOW;
            default:                                  colour_of = LSFS_OFF;
        endcase
    endfunction

    localparam logic [`LSFS_MS_W-1:0] ON_MS  = `LSFS_MS_W'(`LSFS_ON_MS);
    localparam logic [`LSFS_MS_W-1:0] GAP_MS = `LSFS_MS_W'(`LSFS_GAP_MS);
    localparam logic [`LSFS_MS_W-1:0] END_MS = `LSFS_MS_W'(`LSFS_FRAME_GAP_MS);

    lsfs_seq_t              seq_r;
    lsfs_seq_t              seq_nxt;
    logic [`LSFS_CNT_W-1:0] left_r;
    logic [`LSFS_CNT_W-1:0] left_nxt;
    logic [`LSFS_CNT_W-1:0] glo_r;
    logic [`LSFS_CNT_W-1:0] glo_nxt;
    logic                   start_r;
    logic                   start_nxt;
    logic                   fs_r;
    logic                   fs_nxt;
    logic                   lit;
    logic                   done;
    logic [`LSFS_MS_W-1:0]  gap_sel;
    lsfs_led_t              led_r;
    lsfs_led_t              led_nxt;
    lsfs_colour_t           col;
    logic                   locked;

    always_comb
    begin
        seq_nxt   = seq_r;
        left_nxt  = left_r;
        glo_nxt   = glo_r;
        start_nxt = 1'b0;
        fs_nxt    = 1'b0;
        locked    = (st_r.gps_sbas_cnt != '0) || (st_r.glonass_cnt != '0);
        gap_sel   = (seq_r == SQ_CLOSE_RED) ? END_MS : GAP_MS;
        case (seq_r)
            SQ_IDLE:
            begin
                if (st_r.power_good)
                begin
                    start_nxt = 1'b1;
                    if (locked)
                    begin
                        seq_nxt  = SQ_OPEN_RED;                      // see [R1]
                        left_nxt = st_r.gps_sbas_cnt;                // see [R7]
                        glo_nxt  = st_r.glonass_cnt;                 // see [R7]
                        fs_nxt   = 1'b1;
                    end
                    else
                    begin
                        seq_nxt = SQ_NOLOCK_RED;                     // see [R6]
                    end
                end
            end
            SQ_OPEN_RED:
            begin
                if (done)
                begin
                    seq_nxt   = (left_r != '0) ? SQ_GREEN_A : SQ_YELLOW;
                    start_nxt = 1'b1;
                end
            end
            SQ_GREEN_A:
            begin
                if (done)
                begin
                    left_nxt  = left_r - 1'b1;                       // see [R2]
                    seq_nxt   = (left_r == 6'h01) ? SQ_YELLOW : SQ_GREEN_A;
                    start_nxt = 1'b1;
                end
            end
            SQ_YELLOW:
            begin
                if (done)
                begin
                    left_nxt  = glo_r;
                    seq_nxt   = (glo_r != '0) ? SQ_GREEN_B : SQ_CLOSE_RED; // see [R3]
                    start_nxt = 1'b1;
                end
            end
            SQ_GREEN_B:
            begin
                if (done)
                begin
                    left_nxt  = left_r - 1'b1;                       // see [R4]
                    seq_nxt   = (left_r == 6'h01) ? SQ_CLOSE_RED : SQ_GREEN_B;
                    start_nxt = 1'b1;
                end
            end
            SQ_CLOSE_RED:
            begin
                if (done)
                begin
                    seq_nxt = SQ_IDLE;                               // see [R5]
                end
            end
            SQ_NOLOCK_RED:
            begin
                if (done)
                begin
                    seq_nxt   = SQ_NOLOCK_YEL;                       // see [R6]
                    start_nxt = 1'b1;
                end
            end
            SQ_NOLOCK_YEL:
            begin
                if (done)
                begin
                    seq_nxt = SQ_IDLE;                               // see [R6]
                end
            end
            default:
            begin
                seq_nxt = SQ_IDLE;
            end
        endcase
        if (!st_r.power_good)
        begin
            seq_nxt   = SQ_IDLE;
            start_nxt = 1'b0;
        end
        col = lit ? colour_of(seq_r) : LSFS_OFF;
        led_nxt.red   = (col == LSFS_RED) || (col == LSFS_YELLOW);
        led_nxt.green = (col == LSFS_GREEN) || (col == LSFS_YELLOW);
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            seq_r   <= SQ_IDLE;
            left_r  <= '0;
            glo_r   <= '0;
            start_r <= 1'b0;
            fs_r    <= 1'b0;
            led_r   <= '0;
        end
        else
        begin
            seq_r   <= seq_nxt;
            left_r  <= left_nxt;
            glo_r   <= glo_nxt;
            start_r <= start_nxt;
            fs_r    <= fs_nxt;
            led_r   <= led_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // every flash uses the same prescaled on time; the gap is GAP_MS except END_MS after the closing red
    lsfs_flash_timer u_timer
    (
        .clk_in    (CLK_IN),
        .rst_in    (RST_IN || !st_r.power_good),
        .start_in  (start_r),
        .on_ms_in  (ON_MS),                                          // see [R7]
        .gap_ms_in (gap_sel),
        .lit_out   (lit),
        .done_out  (done)
    );

    assign LED_OUT         = led_r;
    assign FRAME_START_OUT = fs_r;
endmodule

// ==== lsfs_led_sequencer_properties.sv ====
`include "lsfs_map.svh"

module lsfs_led_sequencer_properties
    import lsfs_pkg::*;
(
    input wire logic                   CLK_IN,
    input wire logic                   RST_IN,
    input wire logic                   POWER_GOOD_IN,
    input wire logic [`LSFS_CNT_W-1:0] GPS_SBAS_CNT_IN,
    input wire logic [`LSFS_CNT_W-1:0] GLONASS_CNT_IN,
    input wire lsfs_led_t              LED_OUT,
    input wire logic                   FRAME_START_OUT
);
    default clocking @(posedge CLK_IN);
    endclocking
    default disable iff (RST_IN);

    sequence red_lit;
        FRAME_START_OUT ##[1:6] (LED_OUT == 2'b10);
    endsequence

    AST_RESET_DARK: assert property ($fell(RST_IN) |->
        LED_OUT == 2'b00 && !FRAME_START_OUT)
        else $error("outputs not idle after reset");
    AST_START_PULSE: assert property (FRAME_START_OUT |=> !FRAME_START_OUT)
        else $error("frame start longer than one cycle");
    AST_FIRST_RED: assert property (FRAME_START_OUT |-> ##[1:6] (LED_OUT == 2'b10))
        else $error("frame did not open with red");
    AST_RED_HOLDS: assert property (red_lit |=> (LED_OUT == 2'b10) [*8])
        else $error("opening red flash cut short");
    AST_START_NEEDS_POWER: assert property (FRAME_START_OUT |->
        $past(POWER_GOOD_IN, 3))
        else $error("frame started without power good");
    AST_POWER_LOSS_DARK: assert property ($fell(POWER_GOOD_IN) |->
        ##[1:8] (LED_OUT == 2'b00))
        else $error("led still lit after power loss");
    AST_DARK_STAYS: assert property (!POWER_GOOD_IN [*8] |->
        LED_OUT == 2'b00 && !FRAME_START_OUT)
        else $error("activity without power good");
    AST_START_NEEDS_LOCK: assert property (FRAME_START_OUT |->
        $past(GPS_SBAS_CNT_IN, 3) != 0 || $past(GLONASS_CNT_IN, 3) != 0)
        else $error("counting frame with no lock");
endmodule

bind lsfs_led_sequencer lsfs_led_sequencer_properties lsfs_led_sequencer_properties_i
(
    .CLK_IN          (CLK_IN),
    .RST_IN          (RST_IN),
    .POWER_GOOD_IN   (POWER_GOOD_IN),
    .GPS_SBAS_CNT_IN (GPS_SBAS_CNT_IN),
    .GLONASS_CNT_IN  (GLONASS_CNT_IN),
    .LED_OUT         (LED_OUT),
    .FRAME_START_OUT (FRAME_START_OUT)
);

// ==== lsfs_led_model.sv ====
module lsfs_led_model
    import lsfs_pkg::*;
(
    input  wire logic      clk_in,
    input  wire lsfs_led_t led_in,
    output lsfs_colour_t   colour_out,
    output logic           change_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // the lamp shows red and green mixed as yellow
    initial colour_out = LSFS_OFF;
    initial change_out = 1'b0;
    always @(negedge clk_in)
    begin
        change_out <= lsfs_colour_t'({led_in.green, led_in.red}) != colour_out;
        colour_out <= lsfs_colour_t'({led_in.green, led_in.red});
    end
endmodule

// ==== test_lsfs_led_sequencer.sv ====
module test_lsfs_led_sequencer;
    import lsfs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk;
    logic         rst;
    logic         pg;
    logic [5:0]   gps;
    logic [5:0]   glo;
    lsfs_led_t    led;
    logic         fs;
    lsfs_colour_t colour;
    logic         change;
    int           failures;
    int           total_checks;
    int           starts;
    lsfs_colour_t exp_q[$];

    lsfs_led_sequencer lsfs_led_sequencer_i (.CLK_IN(clk), .RST_IN(rst), .POWER_GOOD_IN(pg),
        .GPS_SBAS_CNT_IN(gps), .GLONASS_CNT_IN(glo), .LED_OUT(led), .FRAME_START_OUT(fs));
    lsfs_led_model lsfs_led_model_i (.clk_in(clk), .led_in(led), .colour_out(colour),
        .change_out(change));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task conclude;
        if (failures == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task check_led(input lsfs_colour_t e, input lsfs_colour_t s);
        total_checks++;
        if (e !== s)
        begin
            failures++;
            $display("[FAIL] led colour expected %0d seen %0d", e, s);
        end
    endtask

    task check_cnt(input string what, input int e, input int s);
        total_checks++;
        if (e != s)
        begin
            failures++;
            $display("[FAIL] %s expected %0d seen %0d", what, e, s);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // monitor: every colour change takes the oldest note
    always @(negedge clk)
        if (fs === 1'b1)
            starts++;

    always @(posedge clk)
        if (change === 1'b1)
        begin
            if (exp_q.size() == 0)
                check_cnt("unexpected led change", 0, 1);
            else
                check_led(exp_q.pop_front(), colour);
        end

    ////////////////////////////////////////////////////////////////////////////////
    task run_case(input logic [5:0] g, input logic [5:0] l);
        int n;
        int locked;
        locked = (g != 6'h00 || l != 6'h00) ? 1 : 0;
        rst <= 1'b1;
        pg <= 1'b0;
        gps <= g;
        glo <= l;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        starts = 0;
        check_led(LSFS_OFF, colour);
        exp_q.push_back(LSFS_RED);
        pg <= 1'b1;
        n = 0;
        while (colour !== LSFS_RED && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        check_cnt("red flash in time", 1, (n < 40) ? 1 : 0);
        check_cnt("frame starts", locked, starts);
        // counts moved mid-frame must not restart or recolour the flash
        if (locked == 1)
        begin
            gps <= ~g;
            glo <= ~l;
        end
        repeat (1000) @(posedge clk);
        check_cnt("frame starts held", locked, starts);
        exp_q.push_back(LSFS_OFF);
        pg <= 1'b0;
        repeat (20) @(posedge clk);
        check_cnt("pending colours", 0, exp_q.size());
    endtask

    initial
    begin
        rst = 1'b1;
        pg = 1'b0;
        gps = 6'h00;
        glo = 6'h00;
        failures = 0;
        total_checks = 0;
        starts = 0;
        void'($urandom(20));
        run_case(6'h00, 6'h00);
        run_case(6'h01, 6'h00);
        run_case(6'h00, 6'h01);
        run_case(6'h3f, 6'h3f);
        run_case(6'($urandom_range(63, 1)), 6'($urandom));
        conclude();
    end

    initial
    begin
        #100000;
        failures++;
        conclude();
    end
endmodule
